//--- shared/spb_pkg.sv
// Purpose: Shared types and constants for the memory power and bank state block
// Assumes: System clock of 40 MHz; command arrives already decoded from the pins
// Notes: Durations of timed states are plain defaults, not device figures

package spb_pkg;

  // Decoded command presented with each rising edge of the link clock
  typedef enum logic [3:0] {
    SPB_CMD_NOP         = 4'h0,
    SPB_CMD_ACTIVATE    = 4'h1,
    SPB_CMD_READ        = 4'h2,
    SPB_CMD_WRITE       = 4'h3,
    SPB_CMD_PRECHARGE   = 4'h4,
    SPB_CMD_BURST_STOP  = 4'h5,
    SPB_CMD_REF_BANK    = 4'h6,
    SPB_CMD_REF_ALL     = 4'h7,
    SPB_CMD_CFG_WRITE   = 4'h8,
    SPB_CMD_CFG_READ    = 4'h9,
    SPB_CMD_RESET       = 4'ha,
    SPB_CMD_SREF_ENTRY  = 4'hb,
    SPB_CMD_DEEP_SLEEP  = 4'hc
  } spb_cmd_e;

  // Device state as seen by one bank
  typedef enum logic [4:0] {
    SPB_ST_POWER_ON       = 5'b00000,
    SPB_ST_RESETTING      = 5'b00001,
    SPB_ST_IDLE           = 5'b00010,
    SPB_ST_ROW_ACTIVE     = 5'b00011,
    SPB_ST_READING        = 5'b00100,
    SPB_ST_WRITING        = 5'b00101,
    SPB_ST_PRECHARGING    = 5'b00110,
    SPB_ST_REF_BANK       = 5'b00111,
    SPB_ST_REF_ALL        = 5'b01000,
    SPB_ST_CFG_WRITING    = 5'b01001,
    SPB_ST_IDLE_CFG_RD    = 5'b01010,
    SPB_ST_ACTIVE_CFG_RD  = 5'b01011,
    SPB_ST_RESET_CFG_RD   = 5'b01100,
    SPB_ST_ACTIVE_PD      = 5'b01101,
    SPB_ST_IDLE_PD        = 5'b01110,
    SPB_ST_RESET_PD       = 5'b01111,
    SPB_ST_SELF_REFRESH   = 5'b10000,
    SPB_ST_DEEP_SLEEP     = 5'b10001
  } spb_state_e;

  localparam int SPB_CMD_W = 4;
  localparam int SPB_CNT_W = 16;

  // Time base
  localparam int SPB_CLK_PERIOD_PS = 25000;
  localparam int SPB_OP_NS = 200;
  // Burst outlasts one slow link period so a follow-up read, write or stop can land
  localparam int SPB_BURST_NS = 400;
  localparam int SPB_INIT_WAIT_NS = 1000;
  localparam int SPB_OP_CYC = (SPB_OP_NS * 1000 + SPB_CLK_PERIOD_PS - 1) / SPB_CLK_PERIOD_PS;
  localparam int SPB_BURST_CYC =
    (SPB_BURST_NS * 1000 + SPB_CLK_PERIOD_PS - 1) / SPB_CLK_PERIOD_PS;
  localparam int SPB_INIT_WAIT_CYC =
    (SPB_INIT_WAIT_NS * 1000 + SPB_CLK_PERIOD_PS - 1) / SPB_CLK_PERIOD_PS;

  // Values after reset
  localparam spb_state_e SPB_RST_STATE = SPB_ST_POWER_ON;
  localparam logic SPB_RST_CKE = 1'b0;
  localparam logic SPB_RST_CS_N = 1'b1;
  localparam logic [SPB_CNT_W-1:0] SPB_RST_CNT = 16'h0000;

endpackage

//--- logic/spb_link_capture.sv
// Purpose: Samples clock gate, select and command on each rising link clock edge
// Assumes: Pins are synchronous to the link clock; the link clock may stop
// Notes: Each edge is handed to the system domain by a toggle with held data

`timescale 1ns/1ps

module spb_link_capture
  import spb_pkg::*;
(
  // Link side
  input wire logic i_clk_link,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic [SPB_CMD_W-1:0] i_cmd,
  // Reset from the system domain
  input wire logic i_rst,
  // Captured edge, stable until the next toggle
  output logic o_evt_tgl,
  output logic o_evt_cke_prev,
  output logic o_evt_cke_cur,
  output logic o_evt_cs_n,
  output logic [SPB_CMD_W-1:0] o_evt_cmd
);

  logic rst_meta_ff;
  logic rst_link_ff;
  logic cke_last_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset brought into the link domain
  always_ff @(posedge i_clk_link)
  begin
    rst_meta_ff <= i_rst;
    rst_link_ff <= rst_meta_ff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Both gate levels travel in one word so the pair is never torn
  always_ff @(posedge i_clk_link)
  begin
    if (rst_link_ff)
    begin
      cke_last_ff <= SPB_RST_CKE;
      o_evt_cke_prev <= SPB_RST_CKE;
      o_evt_cke_cur <= SPB_RST_CKE;
      o_evt_cs_n <= SPB_RST_CS_N;
      o_evt_cmd <= SPB_CMD_NOP;
      o_evt_tgl <= 1'b0;
    end
    else
    begin
      cke_last_ff <= i_cke;
      o_evt_cke_prev <= cke_last_ff;
      o_evt_cke_cur <= i_cke;
      o_evt_cs_n <= i_cs_n;
      o_evt_cmd <= i_cmd;
      o_evt_tgl <= ~o_evt_tgl;
    end
  end

endmodule

//--- logic/spb_power_bank_fsm.sv
// Purpose: Power state and bank command state machine of the memory device
// Assumes: Command decoded upstream; link clock much slower than the system clock
// Notes: State machine runs on the system clock; sleep exit needs no link edge
//
// Contract
// - Power transitions compare clock gate at this edge with the previous edge.
// - Active power-down holds while clock gate is low on both edges.
// - Gate rise with select high leaves active power-down to active.
// - Gate rise with select high leaves idle power-down to idle; low holds.
// - Resetting power-down exit goes idle if init wait expired, else resetting.
// - Deep sleep holds while gate low; rise with select high goes power-on.
// - Self refresh exit goes idle; controller then sends only no-ops.
// - Gate fall with select high and bank active enters active power-down.
// - Gate fall with select high and banks idle enters idle power-down.
// - Gate fall with select low in idle enters self refresh or deep sleep.
// - Gate fall with select high while resetting enters resetting power-down.
// - Gate high on both edges decodes the command normally.
// - Idle bank: activate, per-bank refresh and all-bank refresh transitions.
// - Idle: config write enters writing, config read enters idle reading.
// - Precharge in idle or row active enters precharging.
// - Row active: read, write, config read enter their states.
// - Reading: read restarts, write to writing, burst stop to active.
// - Writing: write restarts, read to reading, burst stop to active.
// - Select and clock gate are sampled on the rising edge only; sleep exit reads the raw pins on the system clock.
// - Self refresh and deep sleep exit are accepted without the clock.

`timescale 1ns/1ps

module spb_power_bank_fsm
  import spb_pkg::*;
(
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link from the memory controller
  input wire logic i_clk_link,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic [SPB_CMD_W-1:0] i_cmd,
  // Status
  output spb_state_e o_state,
  output logic o_power_down,
  output logic o_busy,
  output logic o_init_expired
);

  logic lk_tgl;
  logic lk_cke_prev;
  logic lk_cke_cur;
  logic lk_cs_n;
  logic [SPB_CMD_W-1:0] lk_cmd;
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic cke_meta_ff;
  logic cke_sync_ff;
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic ev_vld;
  logic sleep_wake;
  logic busy_done;
  logic ld_busy;
  spb_state_e state_ff;
  spb_state_e nxt_state;
  logic [SPB_CNT_W-1:0] busy_cnt_ff;
  logic [SPB_CNT_W-1:0] init_cnt_ff;
  logic init_run_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_pd(input spb_state_e st);
    is_pd = (st == SPB_ST_ACTIVE_PD) || (st == SPB_ST_IDLE_PD) || (st == SPB_ST_RESET_PD)
         || (st == SPB_ST_SELF_REFRESH) || (st == SPB_ST_DEEP_SLEEP);
  endfunction

  function automatic logic [SPB_CNT_W-1:0] busy_len(input spb_state_e st);
    case (st)
      SPB_ST_READING, SPB_ST_WRITING: busy_len = SPB_CNT_W'(SPB_BURST_CYC);
      SPB_ST_PRECHARGING, SPB_ST_REF_BANK, SPB_ST_REF_ALL, SPB_ST_CFG_WRITING,
      SPB_ST_IDLE_CFG_RD, SPB_ST_ACTIVE_CFG_RD, SPB_ST_RESET_CFG_RD:
        busy_len = SPB_CNT_W'(SPB_OP_CYC);
      default: busy_len = SPB_RST_CNT;
    endcase
  endfunction

  // Command decode with gate high on both edges; unlisted pairs keep the state
  function automatic spb_state_e cmd_next(input spb_state_e st, input spb_cmd_e cmd);
    cmd_next = st;
    case (st)
      SPB_ST_POWER_ON:
        if (cmd == SPB_CMD_RESET)
          cmd_next = SPB_ST_RESETTING;
      SPB_ST_IDLE:
        case (cmd)
          SPB_CMD_ACTIVATE: cmd_next = SPB_ST_ROW_ACTIVE;
          SPB_CMD_REF_BANK: cmd_next = SPB_ST_REF_BANK;
          SPB_CMD_REF_ALL: cmd_next = SPB_ST_REF_ALL;
          SPB_CMD_CFG_WRITE: cmd_next = SPB_ST_CFG_WRITING;
          SPB_CMD_CFG_READ: cmd_next = SPB_ST_IDLE_CFG_RD;
          SPB_CMD_RESET: cmd_next = SPB_ST_RESETTING;
          SPB_CMD_PRECHARGE: cmd_next = SPB_ST_PRECHARGING;
          default: cmd_next = st;
        endcase
      SPB_ST_ROW_ACTIVE:
        case (cmd)
          SPB_CMD_READ: cmd_next = SPB_ST_READING;
          SPB_CMD_WRITE: cmd_next = SPB_ST_WRITING;
          SPB_CMD_CFG_READ: cmd_next = SPB_ST_ACTIVE_CFG_RD;
          SPB_CMD_PRECHARGE: cmd_next = SPB_ST_PRECHARGING;
          default: cmd_next = st;
        endcase
      SPB_ST_READING, SPB_ST_WRITING:
        case (cmd)
          SPB_CMD_READ: cmd_next = SPB_ST_READING;
          SPB_CMD_WRITE: cmd_next = SPB_ST_WRITING;
          SPB_CMD_BURST_STOP: cmd_next = SPB_ST_ROW_ACTIVE;
          default: cmd_next = st;
        endcase
      SPB_ST_RESETTING:
        if (cmd == SPB_CMD_CFG_READ)
          cmd_next = SPB_ST_RESET_CFG_RD;
      default: cmd_next = st;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link-side capture and crossings

  spb_link_capture u_capture (
    .i_clk_link(i_clk_link),
    .i_cke(i_cke),
    .i_cs_n(i_cs_n),
    .i_cmd(i_cmd),
    .i_rst(i_rst),
    .o_evt_tgl(lk_tgl),
    .o_evt_cke_prev(lk_cke_prev),
    .o_evt_cke_cur(lk_cke_cur),
    .o_evt_cs_n(lk_cs_n),
    .o_evt_cmd(lk_cmd)
  );

  // Event word is held a full link period, far longer than the toggle path
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end
    else
    begin
      tgl_meta_ff <= lk_tgl;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
    end
  end

  assign ev_vld = tgl_sync_ff ^ tgl_seen_ff;

  // Raw pin levels for the clockless sleep exit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cke_meta_ff <= SPB_RST_CKE;
      cke_sync_ff <= SPB_RST_CKE;
      cs_meta_ff <= SPB_RST_CS_N;
      cs_sync_ff <= SPB_RST_CS_N;
    end
    else
    begin
      cke_meta_ff <= i_cke;
      cke_sync_ff <= cke_meta_ff;
      cs_meta_ff <= i_cs_n;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // Link clock may be stopped in these states, so no edge is awaited
  assign sleep_wake = cke_sync_ff && cs_sync_ff
    && ((state_ff == SPB_ST_SELF_REFRESH) || (state_ff == SPB_ST_DEEP_SLEEP));

  assign busy_done = (busy_len(state_ff) != SPB_RST_CNT) && (busy_cnt_ff == SPB_RST_CNT);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_state = state_ff;
    ld_busy = 1'b0;
    if (sleep_wake)
    begin
      if (state_ff == SPB_ST_SELF_REFRESH)
        nxt_state = SPB_ST_IDLE;
      else
        nxt_state = SPB_ST_POWER_ON;
    end
    else if (ev_vld)
    begin
      if (!lk_cke_prev && lk_cke_cur)
      begin
        if (lk_cs_n)
        begin
          case (state_ff)
            SPB_ST_ACTIVE_PD: nxt_state = SPB_ST_ROW_ACTIVE;
            SPB_ST_IDLE_PD: nxt_state = SPB_ST_IDLE;
            SPB_ST_RESET_PD:
              nxt_state = init_run_ff ? SPB_ST_RESETTING : SPB_ST_IDLE;
            default: nxt_state = state_ff;
          endcase
        end
      end
      else if (lk_cke_prev && !lk_cke_cur)
      begin
        case (state_ff)
          SPB_ST_ROW_ACTIVE:
            if (lk_cs_n)
              nxt_state = SPB_ST_ACTIVE_PD;
          SPB_ST_IDLE:
            if (lk_cs_n)
              nxt_state = SPB_ST_IDLE_PD;
            else if (lk_cmd == SPB_CMD_SREF_ENTRY)
              nxt_state = SPB_ST_SELF_REFRESH;
            else if (lk_cmd == SPB_CMD_DEEP_SLEEP)
              nxt_state = SPB_ST_DEEP_SLEEP;
          SPB_ST_RESETTING:
            if (lk_cs_n)
              nxt_state = SPB_ST_RESET_PD;
          default: nxt_state = state_ff;
        endcase
      end
      else if (lk_cke_prev && lk_cke_cur && !lk_cs_n)
      begin
        nxt_state = cmd_next(state_ff, spb_cmd_e'(lk_cmd));
        ld_busy = (nxt_state != state_ff) || (nxt_state == SPB_ST_READING)
               || (nxt_state == SPB_ST_WRITING);
      end
      // Low on both edges falls through: power-down states hold
    end
    else if (busy_done)
    begin
      if ((state_ff == SPB_ST_ACTIVE_CFG_RD) || (state_ff == SPB_ST_READING)
          || (state_ff == SPB_ST_WRITING))
        nxt_state = SPB_ST_ROW_ACTIVE;
      else
        nxt_state = SPB_ST_IDLE;
    end
    else if ((state_ff == SPB_ST_RESETTING) && !init_run_ff)
      nxt_state = SPB_ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and status registers

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_ff <= SPB_RST_STATE;
      o_power_down <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      o_power_down <= is_pd(nxt_state);
      o_busy <= (busy_len(nxt_state) != SPB_RST_CNT) || (nxt_state == SPB_ST_RESETTING);
    end
  end

  assign o_state = state_ff;

  // Timed states; a repeated read or write reloads the burst
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      busy_cnt_ff <= SPB_RST_CNT;
    else if (ld_busy)
      busy_cnt_ff <= busy_len(nxt_state);
    else if (busy_cnt_ff != SPB_RST_CNT)
      busy_cnt_ff <= busy_cnt_ff - 1'b1;
  end

  // Init wait keeps running through resetting power-down
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      init_cnt_ff <= SPB_RST_CNT;
      init_run_ff <= 1'b0;
      o_init_expired <= 1'b0;
    end
    else if (ld_busy && (nxt_state == SPB_ST_RESETTING))
    begin
      init_cnt_ff <= SPB_CNT_W'(SPB_INIT_WAIT_CYC);
      init_run_ff <= 1'b1;
      o_init_expired <= 1'b0;
    end
    else if (init_run_ff)
    begin
      init_cnt_ff <= init_cnt_ff - 1'b1;
      if (init_cnt_ff == 16'h0001)
      begin
        init_run_ff <= 1'b0;
        o_init_expired <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb_sys @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_apd_hold;
    ev_vld && (state_ff == SPB_ST_ACTIVE_PD) && !lk_cke_prev && !lk_cke_cur
      |=> (state_ff == SPB_ST_ACTIVE_PD);
  endproperty
  a_apd_hold: assert property (p_apd_hold)
    else $error("active power-down left with gate low");

  property p_apd_exit;
    ev_vld && (state_ff == SPB_ST_ACTIVE_PD) && !lk_cke_prev && lk_cke_cur && lk_cs_n
      |=> (state_ff == SPB_ST_ROW_ACTIVE) && !o_power_down;
  endproperty
  a_apd_exit: assert property (p_apd_exit)
    else $error("active power-down exit did not reach active");

  property p_ipd_exit;
    ev_vld && (state_ff == SPB_ST_IDLE_PD) && !lk_cke_prev && lk_cke_cur && lk_cs_n
      |=> (state_ff == SPB_ST_IDLE);
  endproperty
  a_ipd_exit: assert property (p_ipd_exit)
    else $error("idle power-down exit did not reach idle");

  property p_rpd_exit;
    ev_vld && (state_ff == SPB_ST_RESET_PD) && !lk_cke_prev && lk_cke_cur && lk_cs_n
      |=> (state_ff == ($past(init_run_ff) ? SPB_ST_RESETTING : SPB_ST_IDLE));
  endproperty
  a_rpd_exit: assert property (p_rpd_exit)
    else $error("resetting power-down exit went to wrong state");

  property p_sleep_wake;
    (state_ff == SPB_ST_DEEP_SLEEP) && cke_sync_ff && cs_sync_ff
      |=> (state_ff == SPB_ST_POWER_ON) ##1 !o_power_down;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("deep sleep not left on raised gate");

  property p_pd_entry;
    ev_vld && lk_cke_prev && !lk_cke_cur && lk_cs_n && (state_ff == SPB_ST_ROW_ACTIVE)
      |=> (state_ff == SPB_ST_ACTIVE_PD) && o_power_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("active power-down not entered");

  property p_sref_entry;
    ev_vld && lk_cke_prev && !lk_cke_cur && !lk_cs_n && (state_ff == SPB_ST_IDLE)
      && (lk_cmd == SPB_CMD_SREF_ENTRY) |=> (state_ff == SPB_ST_SELF_REFRESH);
  endproperty
  a_sref_entry: assert property (p_sref_entry)
    else $error("self refresh not entered");

  property p_activate;
    ev_vld && lk_cke_prev && lk_cke_cur && !lk_cs_n && (state_ff == SPB_ST_IDLE)
      && (lk_cmd == SPB_CMD_ACTIVATE) |=> (state_ff == SPB_ST_ROW_ACTIVE);
  endproperty
  a_activate: assert property (p_activate)
    else $error("activate did not open the row");

  property p_precharge_done;
    (state_ff == SPB_ST_IDLE) ##1 (state_ff == SPB_ST_PRECHARGING)
      |-> ##[1:16] (state_ff == SPB_ST_IDLE);
  endproperty
  a_precharge_done: assert property (p_precharge_done)
    else $error("precharge never returned to idle");

  property p_nop_hold;
    ev_vld && lk_cke_prev && lk_cke_cur && lk_cs_n
      && ((state_ff == SPB_ST_IDLE) || (state_ff == SPB_ST_ROW_ACTIVE))
      |=> $stable(state_ff);
  endproperty
  a_nop_hold: assert property (p_nop_hold)
    else $error("no-operation changed the state");

  c_sref_cycle: cover property ((state_ff == SPB_ST_SELF_REFRESH) ##[1:400]
    (state_ff == SPB_ST_IDLE));
  c_read_stop: cover property ((state_ff == SPB_ST_READING) ##1
    (state_ff == SPB_ST_ROW_ACTIVE));
  c_reset_pd: cover property ((state_ff == SPB_ST_RESET_PD) ##[1:400]
    (state_ff == SPB_ST_IDLE));
  c_deep_sleep: cover property ((state_ff == SPB_ST_DEEP_SLEEP) ##1
    (state_ff == SPB_ST_POWER_ON));

endmodule

//--- test/spb_ctrl_model.sv
// Purpose: Behavioural memory controller driving the link pins of the device
// Assumes: Link clock period of 160 ns, stopped between frames
// Notes: Command bits are inverted once released so stale values never match

`timescale 1ns/1ps

module spb_ctrl_model
  import spb_pkg::*;
#(
  parameter int POWERDOWN_EXIT_EDGES = 2,
  parameter int SELFREFRESH_EXIT_EDGES = 3
)
(
  // Link pins toward the device
  output logic o_clk_link,
  output logic o_cke,
  output logic o_cs_n,
  output logic [SPB_CMD_W-1:0] o_cmd
);

  initial
  begin
    o_clk_link = 1'b0;
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_cmd = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One link clock pulse; pins held through the rising edge
  task automatic edge_out(input logic cke, input logic cs_n, input logic [SPB_CMD_W-1:0] cmd);
    o_cke = cke;
    o_cs_n = cs_n;
    o_cmd = cmd;
    #80 o_clk_link = 1'b1;
    #40 o_cmd = ~cmd;
    #40 o_clk_link = 1'b0;
  endtask

  task automatic send(input logic cke, input logic cs_n, input logic [SPB_CMD_W-1:0] cmd);
    logic was_low;
    was_low = ~o_cke;
    edge_out(cke, cs_n, cmd);
    if (was_low && cke)
      repeat (POWERDOWN_EXIT_EDGES) edge_out(1'b1, 1'b1, SPB_CMD_NOP);
  endtask

  // Wake from self refresh or deep sleep with the clock stopped
  task automatic wake();
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    #200;
    repeat (SELFREFRESH_EXIT_EDGES) edge_out(1'b1, 1'b1, SPB_CMD_NOP);
  endtask

endmodule

//--- test/spb_power_bank_fsm_tb.sv
// Purpose: Self-checking bench for the power and bank state machine
// Assumes: State settles within two system cycles after a link pulse ends
// Notes: Reset is held over three link edges so the link side also clears

`timescale 1ns/1ps

module spb_power_bank_fsm_tb
  import spb_pkg::*;
;
  logic clk_sys;
  logic rst;
  logic clk_link;
  logic cke;
  logic cs_n;
  logic [SPB_CMD_W-1:0] cmd;
  spb_state_e state;
  logic pd;
  logic busy;
  logic init_exp;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] seed = 32'h22e2;
  logic [31:0] r;

  spb_power_bank_fsm DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_link(clk_link),
    .i_cke(cke), .i_cs_n(cs_n), .i_cmd(cmd), .o_state(state), .o_power_down(pd),
    .o_busy(busy), .o_init_expired(init_exp));

  spb_ctrl_model ctl (.o_clk_link(clk_link), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic pd_of(input spb_state_e s);
    return s inside {SPB_ST_ACTIVE_PD, SPB_ST_IDLE_PD, SPB_ST_RESET_PD,
      SPB_ST_SELF_REFRESH, SPB_ST_DEEP_SLEEP};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic see(input spb_state_e exp);
    check("state", 8'(state), 8'(exp));
    check("power_down", 8'(pd), 8'(pd_of(exp)));
  endtask

  task automatic step(input logic k, input logic c, input logic [3:0] cm, input spb_state_e e);
    ctl.send(k, c, cm);
    repeat (2) @(negedge clk_sys);
    see(e);
  endtask

  // Timed state must fall back to its home state
  task automatic step_back(input spb_cmd_e cm, input spb_state_e e, input spb_state_e home);
    step(1'b1, 1'b0, cm, e);
    repeat (20) @(negedge clk_sys);
    see(home);
  endtask

  task automatic report_and_stop();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #2ms;
    error_cnt++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    repeat (3) ctl.send(1'b1, 1'b1, SPB_CMD_NOP);
    @(negedge clk_sys);
    rst = 1'b0;
    // Link side leaves reset only on link edges; the third one refills the gate history
    repeat (3) ctl.send(1'b1, 1'b1, SPB_CMD_NOP);
    see(SPB_ST_POWER_ON);
    check("busy", 8'(busy), 8'h00);
    check("init", 8'(init_exp), 8'h00);
    step(1'b1, 1'b0, SPB_CMD_RESET, SPB_ST_RESETTING);
    check("busy", 8'(busy), 8'h01);
    step(1'b0, 1'b1, SPB_CMD_NOP, SPB_ST_RESET_PD);
    r = xs();
    step(1'b0, r[4], r[3:0], SPB_ST_RESET_PD);
    repeat (60) @(negedge clk_sys);
    step(1'b1, 1'b1, SPB_CMD_NOP, SPB_ST_IDLE);
    check("init", 8'(init_exp), 8'h01);
    step(1'b1, 1'b0, SPB_CMD_RESET, SPB_ST_RESETTING);
    check("init", 8'(init_exp), 8'h00);
    step(1'b0, 1'b1, SPB_CMD_NOP, SPB_ST_RESET_PD);
    // Exit well before the init wait runs out
    step(1'b1, 1'b1, SPB_CMD_NOP, SPB_ST_RESETTING);
    repeat (60) @(negedge clk_sys);
    see(SPB_ST_IDLE);
    check("init", 8'(init_exp), 8'h01);
    step_back(SPB_CMD_CFG_WRITE, SPB_ST_CFG_WRITING, SPB_ST_IDLE);
    step_back(SPB_CMD_CFG_READ, SPB_ST_IDLE_CFG_RD, SPB_ST_IDLE);
    step_back(SPB_CMD_REF_BANK, SPB_ST_REF_BANK, SPB_ST_IDLE);
    step_back(SPB_CMD_REF_ALL, SPB_ST_REF_ALL, SPB_ST_IDLE);
    step_back(SPB_CMD_PRECHARGE, SPB_ST_PRECHARGING, SPB_ST_IDLE);
    // Deselected edges carry random command bits and must not decode
    repeat (6)
    begin
      r = xs();
      step(1'b1, 1'b1, r[3:0], SPB_ST_IDLE);
    end
    step(1'b1, 1'b0, SPB_CMD_NOP, SPB_ST_IDLE);
    step(1'b0, 1'b1, SPB_CMD_NOP, SPB_ST_IDLE_PD);
    r = xs();
    step(1'b0, r[4], r[3:0], SPB_ST_IDLE_PD);
    step(1'b1, 1'b1, SPB_CMD_NOP, SPB_ST_IDLE);
    step(1'b1, 1'b0, SPB_CMD_ACTIVATE, SPB_ST_ROW_ACTIVE);
    step_back(SPB_CMD_READ, SPB_ST_READING, SPB_ST_ROW_ACTIVE);
    step_back(SPB_CMD_WRITE, SPB_ST_WRITING, SPB_ST_ROW_ACTIVE);
    step_back(SPB_CMD_CFG_READ, SPB_ST_ACTIVE_CFG_RD, SPB_ST_ROW_ACTIVE);
    // Follow-up commands land while the burst still runs
    step(1'b1, 1'b0, SPB_CMD_READ, SPB_ST_READING);
    step(1'b1, 1'b0, SPB_CMD_WRITE, SPB_ST_WRITING);
    step(1'b1, 1'b0, SPB_CMD_BURST_STOP, SPB_ST_ROW_ACTIVE);
    step(1'b1, 1'b0, SPB_CMD_WRITE, SPB_ST_WRITING);
    step(1'b1, 1'b0, SPB_CMD_READ, SPB_ST_READING);
    step(1'b1, 1'b0, SPB_CMD_BURST_STOP, SPB_ST_ROW_ACTIVE);
    step(1'b1, 1'b0, SPB_CMD_WRITE, SPB_ST_WRITING);
    step(1'b1, 1'b0, SPB_CMD_WRITE, SPB_ST_WRITING);
    // Past the end of the first burst: only a reload keeps it writing
    repeat (10) @(negedge clk_sys);
    see(SPB_ST_WRITING);
    repeat (8) @(negedge clk_sys);
    see(SPB_ST_ROW_ACTIVE);
    step(1'b0, 1'b1, SPB_CMD_NOP, SPB_ST_ACTIVE_PD);
    r = xs();
    step(1'b0, r[4], r[3:0], SPB_ST_ACTIVE_PD);
    step(1'b1, 1'b1, SPB_CMD_NOP, SPB_ST_ROW_ACTIVE);
    step_back(SPB_CMD_PRECHARGE, SPB_ST_PRECHARGING, SPB_ST_IDLE);
    step(1'b0, 1'b0, SPB_CMD_SREF_ENTRY, SPB_ST_SELF_REFRESH);
    ctl.wake();
    see(SPB_ST_IDLE);
    step(1'b0, 1'b0, SPB_CMD_DEEP_SLEEP, SPB_ST_DEEP_SLEEP);
    ctl.wake();
    see(SPB_ST_POWER_ON);
    report_and_stop();
  end

endmodule
